// ===== inc/namf_pkg.sv
// Shared types, register map and timing constants of the node address mode framer.
`default_nettype none
package namf_pkg;

  // Timing: one millisecond tick derived from the 10 ns reference clock.
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned MS_NS         = 1000000;
  localparam int unsigned CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_STATUS    = 8'h04;
  localparam logic [7:0] OFS_ADDR_LEN  = 8'h08;
  localparam logic [7:0] OFS_BCAST1    = 8'h0c;
  localparam logic [7:0] OFS_DELIM     = 8'h10;
  localparam logic [7:0] OFS_WILDCARD  = 8'h14;
  localparam logic [7:0] OFS_REPLY_OFS = 8'h18;
  localparam logic [7:0] OFS_QUERY_LEN = 8'h1c;
  localparam logic [7:0] OFS_TIMES     = 8'h20;
  localparam logic [7:0] OFS_INDEX     = 8'h24;
  localparam logic [7:0] OFS_QUERY_DAT = 8'h28;
  localparam logic [7:0] OFS_MADDR_DAT = 8'h2c;
  localparam logic [7:0] OFS_HADDR_DAT = 8'h30;

  // Sizes and limits.
  localparam int unsigned QUERY_BYTES = 48;
  localparam int unsigned ADDR_BYTES  = 16;
  localparam logic [4:0]  ADDR_LEN_MIN = 5'h01;
  localparam logic [4:0]  ADDR_LEN_MAX = 5'h10;
  localparam logic [2:0]  MAX_TRIES    = 3'h5;

  // Reset values.
  localparam logic [4:0]  ADDR_LEN_RST  = 5'h06;
  localparam logic [7:0]  FSTART_RST    = 8'h68;
  localparam logic [7:0]  FSTOP_RST     = 8'h16;
  localparam logic [7:0]  BC_WC_RST     = 8'hff;
  localparam logic [7:0]  MC_WC_RST     = 8'hfe;
  localparam logic [5:0]  REPLY_OFS_RST = 6'h01;
  localparam logic [15:0] BOOT_MS_RST   = 16'h0064;
  localparam logic [15:0] RESP_MS_RST   = 16'h01f4;

  typedef enum logic [2:0] {
    NAMF_OFF  = 3'b000,
    NAMF_BOOT = 3'b001,
    NAMF_SEND = 3'b010,
    NAMF_WAIT = 3'b011,
    NAMF_RUN  = 3'b100
  } namf_seq_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } namf_wb_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
  } namf_strm_t;

endpackage
`default_nettype wire

// ===== hw/namf_ms_timer.sv
// Millisecond timer used for the host boot delay and the reply timeout.
`timescale 1ns/10ps
`default_nettype none
module namf_ms_timer #(
  parameter int unsigned CYC_PER_MS = namf_pkg::CYC_PER_MS
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        start,
  input  wire logic [15:0] ms,
  output var  logic        expired
);
  import namf_pkg::*;

  typedef struct packed {
    logic        run;
    logic [15:0] ms_left;
    logic [31:0] cyc;
    logic        expired;
  } namf_tmr_t;

  namf_tmr_t q;
  namf_tmr_t next_q;

  always_comb begin
    next_q = q;
    next_q.expired = 1'b0;
    if (start) begin
      next_q.run = 1'b1;
      next_q.ms_left = ms;
      next_q.cyc = 32'h0;
    end else if (q.run) begin
      if (q.ms_left == 16'h0) begin
        next_q.run = 1'b0;
        next_q.expired = 1'b1;
      end else if (q.cyc == CYC_PER_MS - 1) begin
        next_q.cyc = 32'h0;
        next_q.ms_left = q.ms_left - 16'h1;
      end else begin
        next_q.cyc = q.cyc + 32'h1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign expired = q.expired;
endmodule
`default_nettype wire

// ===== hw/namf_addr_match.sv
// Compares one received address byte with the own address or a wildcard.
`timescale 1ns/10ps
`default_nettype none
module namf_addr_match (
  input  wire logic [7:0]       rx_byte,
  input  wire logic [3:0]       index,
  input  wire logic [15:0][7:0] own_addr,
  input  wire logic [7:0]       bc_wc,
  input  wire logic [7:0]       mc_wc,
  output var  logic             hit
);
  import namf_pkg::*;

  // Wildcards match a whole group, so any byte equal to one is accepted.
  always_comb begin
    hit = (rx_byte == own_addr[index]) || (rx_byte == bc_wc) || (rx_byte == mc_wc);
  end
endmodule
`default_nettype wire

// ===== hw/namf_top.sv
// Address mode framer: host address query, head insertion and head removal.
//
// Local design decisions: the register offsets and register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
module namf_top #(
  parameter int unsigned CYC_PER_MS = namf_pkg::CYC_PER_MS
) (
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  input  wire namf_pkg::namf_wb_req_t wb_req,
  output var  logic                   wb_ack,
  output var  logic [31:0]            wb_rdat,
  input  wire namf_pkg::namf_strm_t   host_rx,
  output var  logic                   host_rx_ready,
  output var  namf_pkg::namf_strm_t   host_tx,
  input  wire logic                   host_tx_ready,
  output var  namf_pkg::namf_strm_t   ul,
  input  wire logic                   ul_ready,
  input  wire namf_pkg::namf_strm_t   dl,
  output var  logic                   dl_ready
);
  import namf_pkg::*;

  typedef struct packed {
    logic                          ack;
    logic [31:0]                   rdat;
    logic                          en;
    logic [4:0]                    alen;
    logic [5:0]                    bc1_len;
    logic [7:0]                    bc1_b0;
    logic [7:0]                    fstart;
    logic [7:0]                    fstop;
    logic [7:0]                    bc_wc;
    logic [7:0]                    mc_wc;
    logic [5:0]                    rofs;
    logic [5:0]                    qlen;
    logic [15:0]                   boot_ms;
    logic [15:0]                   resp_ms;
    logic [5:0]                    idx;
    logic [QUERY_BYTES-1:0][7:0]   query;
    logic [ADDR_BYTES-1:0][7:0]    maddr;
    logic [ADDR_BYTES-1:0][7:0]    haddr;
    namf_seq_t                     seq;
    logic [2:0]                    tries;
    logic                          gave_up;
    logic                          addr_ok;
    logic [5:0]                    qi;
    logic                          tmr_go;
    logic [15:0]                   tmr_ms;
    logic                          rx_rdy;
    logic                          rx_in;
    logic [5:0]                    rx_pos;
    logic [4:0]                    hd;
    logic                          pend;
    logic [7:0]                    pend_d;
    namf_strm_t                    ul;
    logic                          dl_rdy;
    logic [4:0]                    dl_pos;
    logic                          dl_drop;
    namf_strm_t                    tx;
  } namf_state_t;

  namf_state_t q;
  namf_state_t next_q;
  logic        tmr_expired;
  logic        dl_hit;
  logic [3:0]  dl_aidx;

  // Byte lane enable of a Wishbone write.
  function automatic logic lane(input namf_wb_req_t r, input int unsigned n);
    lane = r.sel[n];
  endfunction

  namf_ms_timer #(
    .CYC_PER_MS(CYC_PER_MS)
  ) u_timer (
    .ref_clk(ref_clk),
    .rst_n  (rst_n),
    .start  (q.tmr_go),
    .ms     (q.tmr_ms),
    .expired(tmr_expired)
  );

  assign dl_aidx = 4'(q.dl_pos - 5'h1);

  namf_addr_match u_match (
    .rx_byte (dl.data),
    .index   (dl_aidx),
    .own_addr(q.maddr),
    .bc_wc   (q.bc_wc),
    .mc_wc   (q.mc_wc),
    .hit     (dl_hit)
  );

  always_comb begin
    logic       host_mode;
    logic       acc;
    logic       dacc;
    logic       ul_free;
    logic       tx_free;
    logic [6:0] cap;
    logic [4:0] hidx;
    logic       wr;
    host_mode = 1'b0;
    acc = 1'b0;
    dacc = 1'b0;
    ul_free = 1'b0;
    tx_free = 1'b0;
    cap = 7'h0;
    hidx = 5'h0;
    wr = 1'b0;
    next_q = q;
    next_q.tmr_go = 1'b0;

    // Host address mode whenever a query is stored, or nothing is stored at all.
    host_mode = (q.qlen != 6'h0) || (q.bc1_len == 6'h0);

    // Register bus: one wait state, ack for one cycle, unmapped reads give zero.
    next_q.ack = 1'b0;
    wr = wb_req.cyc && wb_req.stb && !q.ack && wb_req.we;
    if (wb_req.cyc && wb_req.stb && !q.ack) begin
      next_q.ack = 1'b1;
      next_q.rdat = 32'h0;
      case (wb_req.adr)
        OFS_CTRL:      next_q.rdat = {31'h0, q.en};
        OFS_STATUS:    next_q.rdat = {20'h0, q.seq, q.tries, q.gave_up, q.addr_ok,
                                      ~host_mode, host_mode, 2'h0};
        OFS_ADDR_LEN:  next_q.rdat = {27'h0, q.alen};
        OFS_BCAST1:    next_q.rdat = {16'h0, q.bc1_b0, 2'h0, q.bc1_len};
        OFS_DELIM:     next_q.rdat = {16'h0, q.fstop, q.fstart};
        OFS_WILDCARD:  next_q.rdat = {16'h0, q.mc_wc, q.bc_wc};
        OFS_REPLY_OFS: next_q.rdat = {26'h0, q.rofs};
        OFS_QUERY_LEN: next_q.rdat = {26'h0, q.qlen};
        OFS_TIMES:     next_q.rdat = {q.resp_ms, q.boot_ms};
        OFS_INDEX:     next_q.rdat = {26'h0, q.idx};
        OFS_QUERY_DAT: next_q.rdat = {24'h0, q.query[q.idx]};
        OFS_MADDR_DAT: next_q.rdat = {24'h0, q.maddr[q.idx[3:0]]};
        OFS_HADDR_DAT: next_q.rdat = {24'h0, q.haddr[q.idx[3:0]]};
        default:       next_q.rdat = 32'h0;
      endcase
    end
    if (wr && lane(wb_req, 0)) begin
      case (wb_req.adr)
        OFS_CTRL:      next_q.en = wb_req.dat[0];
        OFS_ADDR_LEN: begin
          if (wb_req.dat[4:0] >= ADDR_LEN_MIN && wb_req.dat[4:0] <= ADDR_LEN_MAX) begin
            next_q.alen = wb_req.dat[4:0];
          end
        end
        OFS_BCAST1:    next_q.bc1_len = wb_req.dat[5:0];
        OFS_DELIM:     next_q.fstart = wb_req.dat[7:0];
        OFS_WILDCARD:  next_q.bc_wc = wb_req.dat[7:0];
        OFS_REPLY_OFS: next_q.rofs = wb_req.dat[5:0];
        OFS_QUERY_LEN: next_q.qlen = (wb_req.dat[5:0] > 6'(QUERY_BYTES)) ?
                                     6'(QUERY_BYTES) : wb_req.dat[5:0];
        OFS_TIMES:     next_q.boot_ms[7:0] = wb_req.dat[7:0];
        OFS_INDEX:     next_q.idx = (wb_req.dat[5:0] >= 6'(QUERY_BYTES)) ?
                                    6'h0 : wb_req.dat[5:0];
        OFS_QUERY_DAT: next_q.query[q.idx] = wb_req.dat[7:0];
        OFS_MADDR_DAT: next_q.maddr[q.idx[3:0]] = wb_req.dat[7:0];
        default:       next_q.en = q.en;
      endcase
    end
    if (wr && lane(wb_req, 1)) begin
      case (wb_req.adr)
        OFS_BCAST1:    next_q.bc1_b0 = wb_req.dat[15:8];
        OFS_DELIM:     next_q.fstop = wb_req.dat[15:8];
        OFS_WILDCARD:  next_q.mc_wc = wb_req.dat[15:8];
        OFS_TIMES:     next_q.boot_ms[15:8] = wb_req.dat[15:8];
        default:       next_q.en = next_q.en;
      endcase
    end
    if (wr && wb_req.adr == OFS_TIMES) begin
      if (lane(wb_req, 2)) begin
        next_q.resp_ms[7:0] = wb_req.dat[23:16];
      end
      if (lane(wb_req, 3)) begin
        next_q.resp_ms[15:8] = wb_req.dat[31:24];
      end
    end

    // Output slots free up when the far side takes them.
    ul_free = !q.ul.valid || ul_ready;
    tx_free = !q.tx.valid || host_tx_ready;
    if (ul_free) begin
      next_q.ul.valid = 1'b0;
    end
    if (tx_free) begin
      next_q.tx.valid = 1'b0;
    end
    acc = host_rx.valid && q.rx_rdy;
    dacc = dl.valid && q.dl_rdy;

    // Power-up address sequence.
    case (q.seq)
      NAMF_OFF: begin
        if (q.en) begin
          if (q.qlen != 6'h0) begin
            next_q.seq = NAMF_BOOT;
            next_q.tmr_go = 1'b1;
            next_q.tmr_ms = q.boot_ms;
          end else begin
            next_q.seq = NAMF_RUN;
          end
        end
      end
      NAMF_BOOT: begin
        if (tmr_expired) begin
          next_q.seq = NAMF_SEND;
          next_q.qi = 6'h0;
        end
      end
      NAMF_SEND: begin
        if (tx_free) begin
          next_q.tx.valid = 1'b1;
          next_q.tx.data = q.query[q.qi];
          next_q.tx.last = (q.qi == q.qlen - 6'h1);
          next_q.qi = q.qi + 6'h1;
          if (q.qi == q.qlen - 6'h1) begin
            next_q.seq = NAMF_WAIT;
            next_q.tries = q.tries + 3'h1;
            next_q.tmr_go = 1'b1;
            next_q.tmr_ms = q.resp_ms;
          end
        end
      end
      NAMF_WAIT: begin
        if (q.addr_ok) begin
          next_q.seq = NAMF_RUN;
        end else if (tmr_expired) begin
          if (q.tries == MAX_TRIES) begin
            next_q.seq = NAMF_RUN;
            next_q.gave_up = 1'b1;
          end else begin
            next_q.seq = NAMF_SEND;
            next_q.qi = 6'h0;
          end
        end
      end
      NAMF_RUN: begin
        next_q.seq = NAMF_RUN;
      end
      default: begin
        next_q.seq = NAMF_OFF;
      end
    endcase

    // Host side parsing; the reply and any later frame share the same layout.
    if (acc) begin
      cap = 7'(q.rx_pos) - 7'(q.rofs);
      if (!q.rx_in) begin
        if (host_rx.data == q.fstart) begin
          next_q.rx_in = 1'b1;
          next_q.rx_pos = 6'h1;
        end
      end else begin
        if (q.rx_pos != 6'h3f) begin
          next_q.rx_pos = q.rx_pos + 6'h1;
        end
        if (host_rx.data == q.fstop) begin
          next_q.rx_in = 1'b0;
          if (host_mode && !q.addr_ok && q.rx_pos >= q.rofs && cap >= 7'(q.alen)) begin
            next_q.addr_ok = 1'b1;
          end
        end else if (host_mode && !q.addr_ok && q.rx_pos >= q.rofs
                     && cap < 7'(q.alen)) begin
          next_q.haddr[cap[3:0]] = host_rx.data;
        end
      end
    end

    // Uplink: host frames to the mesh, with the head inserted in module mode.
    if (q.seq == NAMF_RUN && acc) begin
      if (!host_mode) begin
        if (!q.rx_in && host_rx.data == q.fstart) begin
          next_q.pend = 1'b1;
          next_q.pend_d = host_rx.data;
          next_q.hd = q.alen + 5'h1;
        end else if (q.rx_in) begin
          next_q.ul.valid = 1'b1;
          next_q.ul.data = host_rx.data;
          next_q.ul.last = (host_rx.data == q.fstop);
        end
      end else begin
        next_q.ul.valid = 1'b1;
        next_q.ul.data = host_rx.data;
        next_q.ul.last = q.rx_in && (host_rx.data == q.fstop);
      end
    end
    if (ul_free && q.hd != 5'h0) begin
      hidx = q.alen + 5'h1 - q.hd;
      next_q.ul.valid = 1'b1;
      next_q.ul.last = 1'b0;
      next_q.ul.data = (hidx == 5'h0) ? q.bc1_b0 : q.maddr[4'(hidx - 5'h1)];
      next_q.hd = q.hd - 5'h1;
    end else if (ul_free && q.pend) begin
      next_q.ul.valid = 1'b1;
      next_q.ul.data = q.pend_d;
      next_q.ul.last = 1'b0;
      next_q.pend = 1'b0;
    end

    // Downlink: mesh frames to the host, head checked and removed in module mode.
    if (dacc) begin
      next_q.dl_pos = dl.last ? 5'h0 : ((q.dl_pos == 5'h1f) ? q.dl_pos : q.dl_pos + 5'h1);
      next_q.dl_drop = dl.last ? 1'b0 : q.dl_drop;
      if (host_mode) begin
        if (q.addr_ok) begin
          next_q.tx.valid = 1'b1;
          next_q.tx.data = dl.data;
          next_q.tx.last = dl.last;
        end
      end else if (q.dl_pos == 5'h0) begin
        next_q.dl_drop = dl.last ? 1'b0 : q.dl_drop;
      end else if (q.dl_pos <= q.alen) begin
        if (!dl_hit && !dl.last) begin
          next_q.dl_drop = 1'b1;
        end
      end else if (!q.dl_drop) begin
        next_q.tx.valid = 1'b1;
        next_q.tx.data = dl.data;
        next_q.tx.last = dl.last;
      end
    end

    // Host ready always in the wait state; otherwise only in run when the single output slot is known to be empty next cycle.
    next_q.rx_rdy = (next_q.seq == NAMF_WAIT) ||
                    (next_q.seq == NAMF_RUN && next_q.hd == 5'h0 && !next_q.pend
                     && !next_q.ul.valid);
    next_q.dl_rdy = (next_q.seq == NAMF_RUN) && !next_q.tx.valid;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      q <= '0;
      q.alen <= ADDR_LEN_RST;
      q.fstart <= FSTART_RST;
      q.fstop <= FSTOP_RST;
      q.bc_wc <= BC_WC_RST;
      q.mc_wc <= MC_WC_RST;
      q.rofs <= REPLY_OFS_RST;
      q.boot_ms <= BOOT_MS_RST;
      q.resp_ms <= RESP_MS_RST;
      q.seq <= NAMF_OFF;
    end else begin
      q <= next_q;
    end
  end

  assign wb_ack = q.ack;
  assign wb_rdat = q.rdat;
  assign host_rx_ready = q.rx_rdy;
  assign host_tx = q.tx;
  assign ul = q.ul;
  assign dl_ready = q.dl_rdy;
endmodule
`default_nettype wire

// ===== sim/namf_assertions.sv
// Concurrent checks on the ports of the node address mode framer.
`timescale 1ns/10ps
`default_nettype none
module namf_assertions #(
  parameter int unsigned CYC_PER_MS = namf_pkg::CYC_PER_MS
) (
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  input  wire namf_pkg::namf_wb_req_t wb_req,
  input  wire logic                   wb_ack,
  input  wire logic [31:0]            wb_rdat,
  input  wire namf_pkg::namf_strm_t   host_rx,
  input  wire logic                   host_rx_ready,
  input  wire namf_pkg::namf_strm_t   host_tx,
  input  wire logic                   host_tx_ready,
  input  wire namf_pkg::namf_strm_t   ul,
  input  wire logic                   ul_ready,
  input  wire namf_pkg::namf_strm_t   dl,
  input  wire logic                   dl_ready
);
  import namf_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence bus_req;
    wb_req.cyc && wb_req.stb && !wb_ack;
  endsequence

  ack_next_a: assert property (bus_req |=> wb_ack)
    else $error("bus request not acknowledged in the next cycle");
  ack_pulse_a: assert property (wb_ack |=> !wb_ack)
    else $error("bus acknowledge longer than one cycle");
  ack_cause_a: assert property (wb_ack |-> $past(wb_req.cyc && wb_req.stb))
    else $error("bus acknowledge without request");
  hole_zero_a: assert property (bus_req and (!wb_req.we && wb_req.adr == 8'hfc)
      |=> wb_rdat == 32'h0)
    else $error("unmapped read not zero");
  query_hold_a: assert property (host_tx.valid && !host_tx_ready
      |=> host_tx.valid && $stable(host_tx.data))
    else $error("byte to host changed before acceptance");
  ul_hold_a: assert property (ul.valid && !ul_ready |=> ul.valid && $stable(ul))
    else $error("uplink byte changed before acceptance");
  // Ready may stay high while bytes are only consumed, so a pending uplink copy, head byte or held start byte blocks it.
  rx_gap_a: assert property (host_rx.valid && host_rx_ready ##1 ul.valid
      |-> !host_rx_ready)
    else $error("host byte accepted while its uplink copy is pending");
  rx_block_a: assert property (ul.valid && !ul_ready |-> !host_rx_ready)
    else $error("host byte accepted while uplink slot full");
  reset_quiet_a: assert property (disable iff (1'b0)
      !rst_n |=> !wb_ack && !ul.valid && !host_tx.valid && !host_rx_ready && !dl_ready)
    else $error("outputs active after reset");
endmodule

bind namf_top namf_assertions #(.CYC_PER_MS(CYC_PER_MS)) u_chk (
  .ref_clk      (ref_clk),
  .rst_n        (rst_n),
  .wb_req       (wb_req),
  .wb_ack       (wb_ack),
  .wb_rdat      (wb_rdat),
  .host_rx      (host_rx),
  .host_rx_ready(host_rx_ready),
  .host_tx      (host_tx),
  .host_tx_ready(host_tx_ready),
  .ul           (ul),
  .ul_ready     (ul_ready),
  .dl           (dl),
  .dl_ready     (dl_ready)
);
`default_nettype wire

// ===== sim/namf_host_model.sv
// Behavioural host that answers address queries and sends frames on demand.
`timescale 1ns/10ps
`default_nettype none
module namf_host_model (
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  input  wire namf_pkg::namf_strm_t host_tx,
  output var  logic                 host_tx_ready,
  output var  namf_pkg::namf_strm_t host_rx,
  input  wire logic                 host_rx_ready,
  input  wire logic                 answer,
  input  wire logic                 slow,
  input  wire logic                 kick,
  input  wire logic [4:0]           len,
  input  wire logic [7:0]           base
);
  import namf_pkg::*;
  logic       busy;
  logic [5:0] pos;
  logic [5:0] stop_pos;
  logic [7:0] fb;
  assign stop_pos = {1'b0, len} + 6'h01;
  // Reply layout: start byte, address from position one, then the stop byte.
  assign fb = (pos == 6'h00) ? FSTART_RST : (pos == stop_pos) ? FSTOP_RST
            : base + {2'h0, pos} - 8'h01;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      busy <= 1'b0;
      pos <= 6'h00;
      host_rx <= '0;
      host_tx_ready <= 1'b0;
    end else begin
      host_tx_ready <= slow ? !host_tx_ready : 1'b1;
      if (host_rx.valid && host_rx_ready) begin
        // Released data shows the inverse so a stale byte never looks valid.
        host_rx <= '{1'b0, ~host_rx.data, 1'b0};
        busy <= (pos != stop_pos);
        pos <= pos + 6'h01;
      end else if (busy) begin
        host_rx <= '{1'b1, fb, 1'b0};
      end else begin
        host_rx.data <= ~host_rx.data;
        if (kick || (answer && host_tx.valid && host_tx_ready && host_tx.last)) begin
          busy <= 1'b1;
          pos <= 6'h00;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== sim/tb_node_address_mode_framer.sv
// Self-checking bench for the node address mode framer.
`timescale 1ns/10ps
`default_nettype none
module tb_node_address_mode_framer;
  import namf_pkg::*;
  typedef struct packed {
    logic        we;
    logic [7:0]  adr;
    logic [31:0] wd;
    logic [31:0] exp;
  } namf_row_t;
  localparam int NROW = 10;
  localparam namf_row_t ROWS [NROW] = '{
    '{1'b0, OFS_ADDR_LEN, 32'h0, 32'h6}, '{1'b0, OFS_DELIM, 32'h0, 32'h1668},
    '{1'b0, OFS_WILDCARD, 32'h0, 32'hfeff}, '{1'b0, OFS_REPLY_OFS, 32'h0, 32'h1},
    '{1'b0, OFS_TIMES, 32'h0, 32'h01f40064}, '{1'b1, OFS_ADDR_LEN, 32'h11, 32'h6},
    '{1'b1, OFS_ADDR_LEN, 32'h10, 32'h10}, '{1'b1, OFS_ADDR_LEN, 32'h0, 32'h10},
    '{1'b1, 8'hfc, 32'hffffffff, 32'h0}, '{1'b0, OFS_HADDR_DAT, 32'h0, 32'h0}};
  logic ref_clk, rst_n, wb_ack, host_rx_ready, host_tx_ready, ul_ready, dl_ready;
  logic answer, slow, kick;
  logic [4:0] plen;
  logic [7:0] base;
  logic [31:0] wb_rdat, rd;
  namf_wb_req_t wb_req;
  namf_strm_t host_rx, host_tx, ul, dl;
  logic [8:0] txq[$], ulq[$];
  int mismatches, n_compared, cyc;

  namf_top #(.CYC_PER_MS(10)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .wb_req(wb_req),
    .wb_ack(wb_ack), .wb_rdat(wb_rdat), .host_rx(host_rx), .host_rx_ready(host_rx_ready),
    .host_tx(host_tx), .host_tx_ready(host_tx_ready), .ul(ul), .ul_ready(ul_ready),
    .dl(dl), .dl_ready(dl_ready));
  namf_host_model u_host (.ref_clk(ref_clk), .rst_n(rst_n), .host_tx(host_tx),
    .host_tx_ready(host_tx_ready), .host_rx(host_rx), .host_rx_ready(host_rx_ready),
    .answer(answer), .slow(slow), .kick(kick), .len(plen), .base(base));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task close_out;
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    if (host_tx.valid && host_tx_ready) txq.push_back({host_tx.last, host_tx.data});
    if (ul.valid && ul_ready) ulq.push_back({ul.last, ul.data});
    ul_ready <= rst_n && !ul_ready;
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      close_out();
    end
  end

  task cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic qchk(ref logic [8:0] q[$], input logic [8:0] e[$]);
    cmp(32'(q.size()), 32'(e.size()));
    foreach (e[i]) if (i < q.size()) cmp({23'h0, q[i]}, {23'h0, e[i]});
    q.delete();
  endtask

  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    wb_req <= '{1'b1, 1'b1, w, a, 4'hf, d};
    do @(posedge ref_clk); while (wb_ack !== 1'b1);
    rd = wb_rdat;
    wb_req <= '0;
    @(posedge ref_clk);
  endtask

  task poll(input int b);
    do wb(1'b0, OFS_STATUS, 32'h0); while (rd[b] !== 1'b1);
  endtask

  task hchk(input logic [7:0] b);
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, OFS_INDEX, i);
      wb(1'b0, OFS_HADDR_DAT, 32'h0);
      cmp(rd, {24'h0, b + 8'(i)});
    end
  endtask

  task do_reset;
    rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
  endtask

  task kick_frame;
    kick <= 1'b1;
    @(posedge ref_clk);
    kick <= 1'b0;
  endtask

  task automatic dlf(input logic [7:0] f[$]);
    foreach (f[i]) begin
      dl <= '{1'b1, f[i], 1'(i == f.size() - 1)};
      do @(posedge ref_clk); while (dl_ready !== 1'b1);
    end
    dl <= '{1'b0, ~f[f.size() - 1], 1'b0};
  endtask

  task setq(input logic [7:0] n);
    wb(1'b1, OFS_ADDR_LEN, 32'h4);
    wb(1'b1, OFS_QUERY_LEN, {24'h0, n});
    wb(1'b1, OFS_INDEX, 32'h0);
    wb(1'b1, OFS_QUERY_DAT, 32'h11);
  endtask

  initial begin
    {rst_n, answer, slow, kick} = '0;
    wb_req = '0;
    dl = '0;
    plen = 5'h04;
    base = 8'ha0;
    do_reset();
    for (int i = 0; i < NROW; i++) begin
      if (ROWS[i].we) wb(1'b1, ROWS[i].adr, ROWS[i].wd);
      wb(1'b0, ROWS[i].adr, 32'h0);
      cmp(rd, ROWS[i].exp);
    end
    // Nothing stored: host mode without a query, address learned from the first frame.
    wb(1'b1, OFS_ADDR_LEN, 32'h4);
    wb(1'b1, OFS_CTRL, 32'h1);
    kick_frame();
    poll(4);
    hchk(8'ha0);
    qchk(ulq, '{9'h068, 9'h0a0, 9'h0a1, 9'h0a2, 9'h0a3, 9'h116});
    // Query answered by the host, address captured and then held.
    do_reset();
    wb(1'b1, OFS_TIMES, 32'h00020001);
    setq(8'h02);
    wb(1'b1, OFS_INDEX, 32'h1);
    wb(1'b1, OFS_QUERY_DAT, 32'h22);
    answer <= 1'b1;
    wb(1'b1, OFS_CTRL, 32'h1);
    poll(4);
    cmp(rd & 32'h1c, 32'h14);
    qchk(txq, '{9'h011, 9'h122});
    hchk(8'ha0);
    cmp(32'(ulq.size()), 32'h0);
    answer <= 1'b0;
    base <= 8'hc0;
    kick_frame();
    while (ulq.size() < 6) @(posedge ref_clk);
    qchk(ulq, '{9'h068, 9'h0c0, 9'h0c1, 9'h0c2, 9'h0c3, 9'h116});
    hchk(8'ha0);
    dlf('{8'h68, 8'h42, 8'h16});
    while (txq.size() < 3) @(posedge ref_clk);
    qchk(txq, '{9'h068, 9'h042, 9'h116});
    // Silent host with a stalling receiver: five tries, then learn from a frame.
    do_reset();
    slow <= 1'b1;
    wb(1'b1, OFS_TIMES, 32'h00010001);
    setq(8'h01);
    wb(1'b1, OFS_CTRL, 32'h1);
    poll(5);
    cmp(rd & 32'h1f0, 32'h160);
    repeat (40) @(posedge ref_clk);
    qchk(txq, '{9'h111, 9'h111, 9'h111, 9'h111, 9'h111});
    dlf('{8'h68, 8'h42, 8'h16});
    repeat (10) @(posedge ref_clk);
    cmp(32'(txq.size()), 32'h0);
    base <= 8'he0;
    kick_frame();
    poll(4);
    hchk(8'he0);
    qchk(ulq, '{9'h068, 9'h0e0, 9'h0e1, 9'h0e2, 9'h0e3, 9'h116});
    // Module address mode: head added uplink, checked and stripped downlink.
    do_reset();
    slow <= 1'b0;
    plen <= 5'h02;
    base <= 8'hb0;
    wb(1'b1, OFS_BCAST1, 32'h0000aa03);
    wb(1'b1, OFS_ADDR_LEN, 32'h2);
    for (int i = 0; i < 2; i++) begin
      wb(1'b1, OFS_INDEX, i);
      wb(1'b1, OFS_MADDR_DAT, 32'h31 + i);
    end
    wb(1'b1, OFS_CTRL, 32'h1);
    wb(1'b0, OFS_STATUS, 32'h0);
    cmp(rd & 32'hc, 32'h8);
    kick_frame();
    while (ulq.size() < 7) @(posedge ref_clk);
    qchk(ulq, '{9'h0aa, 9'h031, 9'h032, 9'h068, 9'h0b0, 9'h0b1, 9'h116});
    dlf('{8'haa, 8'h31, 8'h32, 8'h55, 8'h66});
    while (txq.size() < 2) @(posedge ref_clk);
    qchk(txq, '{9'h055, 9'h166});
    dlf('{8'haa, 8'hff, 8'hfe, 8'h77});
    while (txq.size() < 1) @(posedge ref_clk);
    qchk(txq, '{9'h177});
    dlf('{8'haa, 8'h31, 8'h99, 8'h88});
    repeat (10) @(posedge ref_clk);
    cmp(32'(txq.size()), 32'h0);
    close_out();
  end
endmodule
`default_nettype wire
